// [design/pcp_host.sv]
// host controller: channel table, divider math, serial sender, axi4-lite registers
//
// Notes on behaviour
// - tx select low only with rx high
// - rx select low only with tx high
// - lock pin high when locked
// - tx data pulses 100 us to 15 ms; a high pulse past 15 ms is not ended, it only sets the long flag
// - output frequency from m, n, a, r
// - prescaler is 64 or 128
// - programmable count 3 to 2047
// - swallow count below programmable count
// - reference count 3 to 16383
// - target is channel minus 21.7 MHz
// - reference count is 21.25 MHz over fcomp
// - fcomp 6.25, 12.5 or 25 kHz
// - n split into quotient and remainder
// - operation bits ahead of reference count
// - charge pump select bit sent as 0
// - channel table sent on each change; the code sends only on a channel write made while idle and in range
// - one bit per rising link clock
// - strobe loads latch named by last bit
`timescale 1ns/1ps
module pcp_host
  import pcp_pkg::*;
#(
  parameter int PULSE_MAX_CYCLES = PULSE_MAX_CYC
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  pcp_link_if.host link, // pins to module
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready // read data ready
);
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  wire rd_go = s_axi_arvalid && !rvalid_ff;
  wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}},
                       {8{s_axi_wstrb[0]}}};
  wire [31:0] wbits = s_axi_wdata & wmask;
  wire w_ctrl = wr_go && s_axi_awaddr == REG_CTRL;
  wire w_chan = wr_go && s_axi_awaddr == REG_CHAN;
  wire w_stat = wr_go && s_axi_awaddr == REG_STAT;
  wire w_txd = wr_go && s_axi_awaddr == REG_TXD;
  wire w_tbl = wr_go && s_axi_awaddr >= REG_TBL
               && s_axi_awaddr < REG_TBL + ADDR_W'(4 * TBL_DEPTH) && s_axi_awaddr[1:0] == 2'h0;
  wire w_hit = w_ctrl || w_chan || w_stat || w_txd || w_tbl;
  wire r_tbl = s_axi_araddr >= REG_TBL
               && s_axi_araddr < REG_TBL + ADDR_W'(4 * TBL_DEPTH) && s_axi_araddr[1:0] == 2'h0;
  wire [TBL_AW-1:0] w_idx = s_axi_awaddr[TBL_AW+1:2];
  wire [TBL_AW-1:0] r_idx = s_axi_araddr[TBL_AW+1:2];
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign s_axi_arready = rd_go;
  // ----------------------------------------
  // software registers and channel table
  // ----------------------------------------
  logic [DIV_W-1:0] tbl_mem [TBL_DEPTH];
  logic [1:0] mode_ff;
  logic presc_ff;
  logic [1:0] fcomp_ff;
  logic [TBL_AW-1:0] chan_ff;
  logic txd_req_ff;
  logic range_err_ff;
  logic long_ff;
  logic busy;
  logic set_err;
  logic set_long;
  logic start;
  always_ff @(posedge aclk) begin
    if (w_tbl) begin
      tbl_mem[w_idx] <= wbits[DIV_W-1:0];
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ff <= MODE_IDLE;
      presc_ff <= 1'b0;
      fcomp_ff <= FCOMP_FAST;
      chan_ff <= 4'h0;
      txd_req_ff <= 1'b0;
      range_err_ff <= 1'b0;
      long_ff <= 1'b0;
    end else begin
      if (w_ctrl) begin
        mode_ff <= wbits[1:0] == 2'h3 ? MODE_IDLE : wbits[1:0];
        presc_ff <= wbits[CTRL_PRESC_BIT];
        fcomp_ff <= wbits[CTRL_FCOMP_LSB+1:CTRL_FCOMP_LSB];
      end
      if (w_chan && !busy) begin
        chan_ff <= wbits[TBL_AW-1:0];
      end
      if (w_txd) begin
        txd_req_ff <= wbits[0];
      end
      // sticky flags, set wins over clear
      range_err_ff <= set_err || (range_err_ff && !(w_stat && wbits[STAT_RANGE_BIT]));
      long_ff <= set_long || (long_ff && !(w_stat && wbits[STAT_LONG_BIT]));
    end
  end
  // ----------------------------------------
  // divider values
  // ----------------------------------------
  // table entry on channel change
  wire [DIV_W-1:0] chan_units = tbl_mem[wbits[TBL_AW-1:0]];
  wire fcomp_ok = fcomp_ff == FCOMP_SLOW || fcomp_ff == FCOMP_MID || fcomp_ff == FCOMP_FAST;
  wire [DIV_W-1:0] off_units = fcomp_ff == FCOMP_SLOW ? OFF_SLOW
                             : fcomp_ff == FCOMP_MID ? OFF_MID : OFF_FAST;
  wire [R_W-1:0] r_val = fcomp_ff == FCOMP_SLOW ? REF_SLOW
                       : fcomp_ff == FCOMP_MID ? REF_MID : REF_FAST;
  wire [DIV_W:0] n_total = {1'b0, chan_units} - {1'b0, off_units};
  wire [DIV_W-6:0] n_quot = presc_ff ? {2'b00, n_total[DIV_W-1:7]}
                                     : {1'b0, n_total[DIV_W-1:6]};
  wire [A_W-1:0] a_val = presc_ff ? n_total[6:0] : {1'b0, n_total[5:0]};
  wire [N_W-1:0] n_val = n_quot[N_W-1:0];
  wire vals_ok = !n_total[DIV_W] && fcomp_ok && n_quot >= (DIV_W-5)'(N_MIN)
                 && n_quot <= (DIV_W-5)'(N_MAX) && {4'h0, a_val} < n_val
                 && r_val >= R_W'(R_MIN) && r_val <= R_W'(R_MAX);
  assign start = w_chan && !busy && vals_ok;
  assign set_err = w_chan && !busy && !vals_ok;
  // operation bits lead the reference word
  wire [SHIFT_W-1:0] ref_word = {CS_1MA5, LDS_LOCK, FC_POS, presc_ff ? SW_128 : SW_64, r_val,
                                 SEL_REF};
  wire [SHIFT_W-1:0] prog_word = {n_val, a_val, SEL_PROG};
  // ----------------------------------------
  // serial sender
  // ----------------------------------------
  pcp_hstate_t state_ff;
  pcp_hstate_t nxt_state;
  logic [2:0] div_ff;
  logic [4:0] bit_ff;
  logic [SHIFT_W-1:0] word_ff;
  logic [SHIFT_W-1:0] prog_ff;
  logic second_ff;
  logic lclk_ff;
  logic ldata_ff;
  logic lstrobe_ff;
  wire half_done = div_ff == 3'(LINK_HALF_CYC - 1);
  assign busy = state_ff != HS_IDLE;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      HS_IDLE: if (start) nxt_state = HS_CLK_LO;
      HS_CLK_LO: if (half_done) nxt_state = HS_CLK_HI;
      HS_CLK_HI: if (half_done) nxt_state = bit_ff == 5'(SHIFT_W - 1) ? HS_STROBE : HS_CLK_LO;
      HS_STROBE: if (half_done) nxt_state = HS_GAP;
      HS_GAP: if (half_done) nxt_state = second_ff ? HS_IDLE : HS_CLK_LO;
      default: nxt_state = HS_IDLE;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= HS_IDLE;
      div_ff <= 3'h0;
      bit_ff <= 5'h00;
      word_ff <= 19'h0_0000;
      prog_ff <= 19'h0_0000;
      second_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      div_ff <= (nxt_state != state_ff || state_ff == HS_IDLE) ? 3'h0 : div_ff + 3'h1;
      if (start) begin
        word_ff <= ref_word;
        prog_ff <= prog_word;
        second_ff <= 1'b0;
        bit_ff <= 5'h00;
      end else if (state_ff == HS_CLK_HI && half_done) begin
        word_ff <= {word_ff[SHIFT_W-2:0], 1'b0};
        bit_ff <= bit_ff + 5'h01;
      end else if (state_ff == HS_GAP && half_done) begin
        word_ff <= prog_ff;
        second_ff <= 1'b1;
        bit_ff <= 5'h00;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lclk_ff <= 1'b0;
      ldata_ff <= 1'b0;
      lstrobe_ff <= 1'b0;
    end else begin
      lclk_ff <= nxt_state == HS_CLK_HI;
      ldata_ff <= (nxt_state == HS_CLK_LO || nxt_state == HS_CLK_HI) &&
                  (start ? ref_word[SHIFT_W-1] : word_ff[SHIFT_W-1]);
      lstrobe_ff <= nxt_state == HS_STROBE;
    end
  end
  // ----------------------------------------
  // mode selects, tx data and lock
  // ----------------------------------------
  logic tsel_ff;
  logic rsel_ff;
  logic txd_ff;
  logic [$clog2(PULSE_MAX_CYCLES+1)-1:0] pw_ff;
  logic lock_s1_ff;
  logic lock_s2_ff;
  // hold each level at least the minimum
  wire may_flip = pw_ff >= ($bits(pw_ff))'(PULSE_MIN_CYC - 1);
  wire flip = txd_req_ff != txd_ff && may_flip;
  assign set_long = txd_ff && pw_ff == ($bits(pw_ff))'(PULSE_MAX_CYCLES - 1) && !flip;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tsel_ff <= 1'b1;
      rsel_ff <= 1'b1;
      txd_ff <= 1'b0;
      pw_ff <= '0;
      lock_s1_ff <= 1'b0;
      lock_s2_ff <= 1'b0;
    end else begin
      // one select low at a time
      tsel_ff <= mode_ff != MODE_TX;
      rsel_ff <= mode_ff != MODE_RX;
      if (flip) begin
        txd_ff <= txd_req_ff;
        pw_ff <= '0;
      end else if (pw_ff != ($bits(pw_ff))'(PULSE_MAX_CYCLES)) begin
        pw_ff <= pw_ff + 1'b1;
      end
      lock_s1_ff <= link.lock_indicator;
      lock_s2_ff <= lock_s1_ff;
    end
  end
  assign link.link_clk = lclk_ff;
  assign link.link_data = ldata_ff;
  assign link.load_strobe = lstrobe_ff;
  assign link.transmit_select_low = tsel_ff;
  assign link.receive_select_low = rsel_ff;
  assign link.tx_data_input = txd_ff;
  // ----------------------------------------
  // bus answers
  // ----------------------------------------
  wire [31:0] rd_ctrl = {27'h000_0000, fcomp_ff, presc_ff, mode_ff};
  wire [31:0] rd_stat = {28'h000_0000, long_ff, range_err_ff, lock_s2_ff, busy};
  wire [31:0] rd_tbl = {14'h0000, tbl_mem[r_idx]};
  wire r_hit = s_axi_araddr == REG_CTRL || s_axi_araddr == REG_CHAN
               || s_axi_araddr == REG_STAT || s_axi_araddr == REG_TXD || r_tbl;
  wire [31:0] rd_val = s_axi_araddr == REG_CTRL ? rd_ctrl
                     : s_axi_araddr == REG_CHAN ? {28'h000_0000, chan_ff}
                     : s_axi_araddr == REG_STAT ? rd_stat
                     : s_axi_araddr == REG_TXD ? {31'h0000_0000, txd_ff}
                     : r_tbl ? rd_tbl : 32'h0000_0000;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= RESP_OKAY;
      rvalid_ff <= 1'b0;
      rresp_ff <= RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else begin
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= w_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
      if (rd_go) begin
        rvalid_ff <= 1'b1;
        rresp_ff <= r_hit ? RESP_OKAY : RESP_SLVERR;
        rdata_ff <= rd_val;
      end else if (s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;
endmodule

// [design/pcp_pkg.sv]
// constants and types shared by both ends of the synthesizer programming link
package pcp_pkg;
  // ----------------------------------------
  // clock and timing
  // ----------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;
  localparam int LINK_HALF_NS = 400;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS / CLK_NS < 1) ? 1 : LINK_HALF_NS / CLK_NS;
  localparam int PULSE_MIN_US = 100;
  localparam int PULSE_MIN_CYC = (PULSE_MIN_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PULSE_MAX_MS = 15;
  localparam int PULSE_MAX_CYC = PULSE_MAX_MS * 1_000_000 / CLK_NS;
  localparam int LOCK_MS = 30;
  localparam int LOCK_CYC = LOCK_MS * 1_000_000 / CLK_NS;
  // ----------------------------------------
  // divider fields and limits
  // ----------------------------------------
  localparam int SHIFT_W = 19;
  localparam int N_W = 11;
  localparam int A_W = 7;
  localparam int R_W = 14;
  localparam int DIV_W = 18;
  localparam int N_MIN = 3;
  localparam int N_MAX = 2047;
  localparam int R_MIN = 3;
  localparam int R_MAX = 16383;
  localparam int PRESC_LO = 64;
  localparam int PRESC_HI = 128;
  localparam int OSC_HZ = 21_250_000;
  localparam int OFFSET_HZ = 21_700_000;
  localparam int FCOMP_HZ_SLOW = 6250;
  localparam int FCOMP_HZ_MID = 12500;
  localparam int FCOMP_HZ_FAST = 25000;
  localparam logic [R_W-1:0] REF_SLOW = R_W'(OSC_HZ / FCOMP_HZ_SLOW);
  localparam logic [R_W-1:0] REF_MID = R_W'(OSC_HZ / FCOMP_HZ_MID);
  localparam logic [R_W-1:0] REF_FAST = R_W'(OSC_HZ / FCOMP_HZ_FAST);
  localparam logic [DIV_W-1:0] OFF_SLOW = DIV_W'(OFFSET_HZ / FCOMP_HZ_SLOW);
  localparam logic [DIV_W-1:0] OFF_MID = DIV_W'(OFFSET_HZ / FCOMP_HZ_MID);
  localparam logic [DIV_W-1:0] OFF_FAST = DIV_W'(OFFSET_HZ / FCOMP_HZ_FAST);
  // ----------------------------------------
  // serial word layout, msb sent first, latch select last
  // ref word:  cs, lds, fc, sw, r[13:0], sel
  // prog word: n[10:0], a[6:0], sel
  // ----------------------------------------
  localparam logic CS_1MA5 = 1'b0;
  localparam logic LDS_LOCK = 1'b0;
  localparam logic FC_POS = 1'b1;
  localparam logic SW_64 = 1'b1;
  localparam logic SW_128 = 1'b0;
  localparam logic SEL_REF = 1'b1;
  localparam logic SEL_PROG = 1'b0;
  localparam int REF_SW_POS = 15;
  localparam int REF_FC_POS = 16;
  localparam int REF_LDS_POS = 17;
  localparam int REF_CS_POS = 18;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_CHAN = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_TXD = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_TBL = 8'h40;
  localparam int TBL_DEPTH = 16;
  localparam int TBL_AW = 4;
  localparam int CTRL_PRESC_BIT = 2;
  localparam int CTRL_FCOMP_LSB = 3;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam int STAT_RANGE_BIT = 2;
  localparam int STAT_LONG_BIT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] FCOMP_SLOW = 2'h0;
  localparam logic [1:0] FCOMP_MID = 2'h1;
  localparam logic [1:0] FCOMP_FAST = 2'h2;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_TX = 2'b01,
    MODE_RX = 2'b10
  } pcp_mode_t;
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_CLK_LO = 3'b001,
    HS_CLK_HI = 3'b010,
    HS_STROBE = 3'b011,
    HS_GAP = 3'b100
  } pcp_hstate_t;
endpackage

// [design/pcp_link_if.sv]
// pins between the host controller and the radio module
`timescale 1ns/1ps
interface pcp_link_if;
  logic link_clk;
  logic link_data;
  logic load_strobe;
  logic transmit_select_low;
  logic receive_select_low;
  logic tx_data_input;
  logic lock_indicator;
  modport host (
    output link_clk, link_data, load_strobe, transmit_select_low, receive_select_low,
    output tx_data_input,
    input lock_indicator
  );
  modport dev (
    input link_clk, link_data, load_strobe, transmit_select_low, receive_select_low,
    input tx_data_input,
    output lock_indicator
  );
endinterface

// [design/pcp_dev.sv]
// radio module end: serial shift register, latches, lock and mode selects
`timescale 1ns/1ps
module pcp_dev
  import pcp_pkg::*;
#(
  parameter int LOCK_CYCLES = LOCK_CYC
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  pcp_link_if.dev link, // pins from host
  output logic tx_enable, // transmitter on
  output logic rx_enable, // receiver on
  output logic rf_tx_data, // data into modulator
  output logic [DIV_W-1:0] div_total, // prescaler times n plus a
  output logic [R_W-1:0] ref_count, // reference divider
  output logic prescaler_128, // prescaler ratio is 128
  output logic locked // lock state
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [5:0] s1_ff;
  logic [5:0] s2_ff;
  logic clk_d_ff;
  logic le_d_ff;
  wire [5:0] pins = {link.tx_data_input, link.receive_select_low, link.transmit_select_low,
                     link.load_strobe, link.link_data, link.link_clk};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_ff <= 6'h18;
      s2_ff <= 6'h18;
      clk_d_ff <= 1'b0;
      le_d_ff <= 1'b0;
    end else begin
      s1_ff <= pins;
      s2_ff <= s1_ff;
      clk_d_ff <= s2_ff[0];
      le_d_ff <= s2_ff[2];
    end
  end
  wire clk_rise = s2_ff[0] && !clk_d_ff;
  wire le_rise = s2_ff[2] && !le_d_ff;
  // ----------------------------------------
  // shift register and latches
  // ----------------------------------------
  logic [SHIFT_W-1:0] sr_ff;
  logic [R_W-1:0] ref_ff;
  logic sw_ff;
  logic [N_W-1:0] n_ff;
  logic [A_W-1:0] a_ff;
  logic ref_ok_ff;
  logic prog_ok_ff;
  wire load_ref = le_rise && sr_ff[0] == SEL_REF;
  wire load_prog = le_rise && sr_ff[0] == SEL_PROG;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sr_ff <= 19'h0_0000;
      ref_ff <= 14'h0000;
      sw_ff <= SW_64;
      n_ff <= 11'h000;
      a_ff <= 7'h00;
      ref_ok_ff <= 1'b0;
      prog_ok_ff <= 1'b0;
    end else begin
      if (clk_rise) begin
        sr_ff <= {sr_ff[SHIFT_W-2:0], s2_ff[1]};
      end
      if (load_ref) begin
        ref_ff <= sr_ff[R_W:1];
        sw_ff <= sr_ff[REF_SW_POS];
        ref_ok_ff <= 1'b1;
      end
      if (load_prog) begin
        n_ff <= sr_ff[SHIFT_W-1:A_W+1];
        a_ff <= sr_ff[A_W:1];
        prog_ok_ff <= 1'b1;
      end
    end
  end
  // ----------------------------------------
  // division and lock
  // ----------------------------------------
  // prescaler choice
  wire [DIV_W-1:0] m_times_n = sw_ff == SW_64 ? {1'b0, n_ff, 6'h00} : {n_ff, 7'h00};
  logic [$clog2(LOCK_CYCLES+1)-1:0] lock_cnt_ff;
  logic lock_ff;
  logic [DIV_W-1:0] div_ff;
  wire set_ok = ref_ok_ff && prog_ok_ff && n_ff >= N_W'(N_MIN) && a_ff < n_ff
                && ref_ff >= R_W'(R_MIN);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_cnt_ff <= '0;
      lock_ff <= 1'b0;
      div_ff <= 18'h0_0000;
    end else begin
      div_ff <= m_times_n + DIV_W'(a_ff);
      if (le_rise || !set_ok) begin
        lock_cnt_ff <= '0;
        lock_ff <= 1'b0;
      end else if (lock_cnt_ff == ($bits(lock_cnt_ff))'(LOCK_CYCLES - 1)) begin
        lock_ff <= 1'b1;
      end else begin
        lock_cnt_ff <= lock_cnt_ff + 1'b1;
      end
    end
  end
  assign link.lock_indicator = lock_ff;
  assign locked = lock_ff;
  assign div_total = div_ff;
  assign ref_count = ref_ff;
  assign prescaler_128 = sw_ff == SW_128;
  // ----------------------------------------
  // mode selects
  // ----------------------------------------
  logic tx_en_ff;
  logic rx_en_ff;
  logic rf_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_en_ff <= 1'b0;
      rx_en_ff <= 1'b0;
      rf_ff <= 1'b0;
    end else begin
      // tx only when tx low, rx high
      tx_en_ff <= !s2_ff[3] && s2_ff[4];
      // rx only when rx low, tx high
      rx_en_ff <= !s2_ff[4] && s2_ff[3];
      rf_ff <= s2_ff[5] && !s2_ff[3] && s2_ff[4];
    end
  end
  assign tx_enable = tx_en_ff;
  assign rx_enable = rx_en_ff;
  assign rf_tx_data = rf_ff;
endmodule

// [sim/pcp_link_checker.sv]
// concurrent checks on the pins between host and radio module
`timescale 1ns/1ps
module pcp_link_checker
  import pcp_pkg::*;
(
  input logic aclk, // clock
  input logic aresetn, // sync reset, low
  input logic link_clk, // serial clock
  input logic link_data, // serial bit
  input logic load_strobe, // latch load
  input logic transmit_select_low, // tx wanted
  input logic receive_select_low, // rx wanted
  input logic tx_data_input, // tx data pin
  input logic lock_indicator // lock pin
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic last_ff, nxt_last;
  logic [10:0] run_ff, nxt_run;
  // cycles the tx data pin has held its level
  assign nxt_last = tx_data_input;
  assign nxt_run = (tx_data_input != last_ff) ? 11'h000 : run_ff + 11'(run_ff != 11'h7ff);
  always_ff @(posedge aclk) begin
    last_ff <= aresetn ? nxt_last : 1'b0;
    run_ff <= aresetn ? nxt_run : 11'h000;
  end
  sequence s_clk_high; link_clk [*4] ##1 !link_clk; endsequence
  sequence s_strobe; load_strobe [*4] ##1 !load_strobe; endsequence
  sequence s_gap; (!link_clk && !load_strobe) [*4]; endsequence
  property p_sel_excl; transmit_select_low || receive_select_low; endproperty
  property p_clk_half; $rose(link_clk) |-> s_clk_high; endproperty
  property p_data_hold; $rose(link_clk) |-> $stable(link_data); endproperty
  property p_strobe_len; $rose(load_strobe) |-> s_strobe; endproperty
  property p_strobe_clk_low; load_strobe |-> !link_clk; endproperty
  property p_gap; $fell(load_strobe) |-> s_gap; endproperty
  property p_lock_drop; $rose(load_strobe) |-> ##[1:8] !lock_indicator; endproperty
  property p_pulse_min; (tx_data_input != last_ff) |-> run_ff >= 11'(PULSE_MIN_CYC - 2); endproperty
  a_sel_excl: assert property (p_sel_excl)
    else $error("both selects low");
  a_clk_half: assert property (p_clk_half)
    else $error("link clock high phase wrong");
  a_data_hold: assert property (p_data_hold)
    else $error("data moved at clock rise");
  a_strobe_len: assert property (p_strobe_len)
    else $error("strobe length wrong");
  a_strobe_clk_low: assert property (p_strobe_clk_low)
    else $error("strobe with clock high");
  a_gap: assert property (p_gap)
    else $error("no gap after strobe");
  a_lock_drop: assert property (p_lock_drop)
    else $error("lock kept over strobe");
  a_pulse_min: assert property (p_pulse_min)
    else $error("tx data pulse too short");
endmodule

// [sim/pll_channel_programming_test.sv]
// self-checking bench for both ends of the synthesizer programming link
`timescale 1ns/1ps
module pll_channel_programming_test;
  import pcp_pkg::*;
  localparam int LOCKC = 50;
  localparam int PMAX = 2000;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, tx_enable, rx_enable, rf_tx_data, p128_o, locked;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [DIV_W-1:0] div_total;
  logic [R_W-1:0] ref_count;
  logic [SHIFT_W-1:0] sh = '0;
  logic [SHIFT_W-1:0] words[$];
  logic [1:0] fcs[3] = '{FCOMP_FAST, FCOMP_MID, FCOMP_SLOW};
  int fhz[3] = '{FCOMP_HZ_FAST, FCOMP_HZ_MID, FCOMP_HZ_SLOW};
  int mismatches = 0;
  int checked = 0;
  pcp_link_if link ();
  pcp_host #(.PULSE_MAX_CYCLES(PMAX)) u_pcp_host (.aclk(aclk), .aresetn(aresetn), .link(link),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  pcp_dev #(.LOCK_CYCLES(LOCKC)) u_pcp_dev (.aclk(aclk), .aresetn(aresetn), .link(link),
    .tx_enable(tx_enable), .rx_enable(rx_enable), .rf_tx_data(rf_tx_data),
    .div_total(div_total), .ref_count(ref_count), .prescaler_128(p128_o), .locked(locked));
  pcp_link_checker u_pcp_link_checker (.aclk(aclk), .aresetn(aresetn), .link_clk(link.link_clk),
    .link_data(link.link_data), .load_strobe(link.load_strobe),
    .transmit_select_low(link.transmit_select_low), .receive_select_low(link.receive_select_low),
    .tx_data_input(link.tx_data_input), .lock_indicator(link.lock_indicator));
  always #50 aclk = ~aclk;
  // serial words as the module latches them
  always @(posedge link.link_clk) sh <= {sh[SHIFT_W-2:0], link.link_data};
  always @(posedge link.load_strobe) words.push_back(sh);
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    chk("bresp", 32'(er), 32'(bresp));
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask
  task automatic stat(output logic [31:0] d);
    logic [1:0] r;
    rd(REG_STAT, d, r);
  endtask
  task automatic prog(input logic [3:0] idx, input logic p, input logic [1:0] fc, input int fhz);
    int m, n, r;
    logic [31:0] d;
    m = p ? PRESC_HI : PRESC_LO;
    n = 433_075_000 / fhz - OFFSET_HZ / fhz;
    r = OSC_HZ / fhz;
    words.delete();
    wr(REG_TBL + {2'b00, idx, 2'b00}, 32'(433_075_000 / fhz));
    wr(REG_CTRL, {27'h0, fc, p, MODE_RX});
    wr(REG_CHAN, {28'h0, idx});
    do stat(d); while (d[STAT_BUSY_BIT] !== 1'b0);
    chk("lock early", 32'h0, 32'(locked));
    chk("ref word", 32'({CS_1MA5, LDS_LOCK, FC_POS, p ? SW_128 : SW_64, R_W'(r), SEL_REF}), 32'(words[0]));
    chk("prog word", 32'({N_W'(n / m), A_W'(n % m), SEL_PROG}), 32'(words[1]));
    chk("div total", 32'(n), 32'(div_total));
    chk("ref count", 32'(r), 32'(ref_count));
    chk("prescaler", 32'(p), 32'(p128_o));
    repeat (LOCKC + 10) @(posedge aclk);
    stat(d);
    chk("lock stat", 32'h1, 32'(d[STAT_LOCK_BIT]));
    chk("lock pin", 32'h1, 32'(link.lock_indicator));
    $display("test channel %0d done", idx);
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    conclude();
  end
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    chk("tx sel idle", 32'h1, 32'(link.transmit_select_low));
    chk("rx sel idle", 32'h1, 32'(link.receive_select_low));
    chk("div idle", 32'h0, 32'(div_total));
    for (int i = 0; i < 3; i++) prog(4'(i), 1'(i), fcs[i], fhz[i]);
    for (int k = 0; k < 4; k++) begin
      wr(REG_CTRL, 32'(k));
      repeat (6) @(posedge aclk);
      chk("tx sel", 32'(k != 1), 32'(link.transmit_select_low));
      chk("rx sel", 32'(k != 2), 32'(link.receive_select_low));
      chk("tx en", 32'(k == 1), 32'(tx_enable));
      chk("rx en", 32'(k == 2), 32'(rx_enable));
    end
    $display("test modes done");
    rd(8'hf0, d, r);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
    chk("unmapped data", 32'h0, d);
    wr(8'hf4, 32'h1, RESP_SLVERR);
    // n too small for n at least 3, then a not below n
    for (int j = 0; j < 2; j++) begin
      words.delete();
      wr(REG_TBL + 8'h04, 32'(OFFSET_HZ / FCOMP_HZ_FAST + (j ? 389 : 100)));
      wr(REG_CTRL, {27'h0, FCOMP_FAST, 1'(j), MODE_RX});
      wr(REG_CHAN, 32'h1);
      repeat (4) @(posedge aclk);
      stat(d);
      chk("range flag", 32'h1, 32'(d[STAT_RANGE_BIT]));
      chk("no words", 32'h0, 32'(words.size()));
      wr(REG_STAT, 32'h4);
      stat(d);
      chk("range clear", 32'h0, 32'(d[STAT_RANGE_BIT]));
    end
    $display("test range done");
    wr(REG_CTRL, 32'(MODE_TX));
    wr(REG_TXD, 32'h1);
    wr(REG_TXD, 32'h0);
    repeat (PULSE_MIN_CYC - 20) @(posedge aclk);
    chk("pulse early", 32'h1, 32'(link.tx_data_input));
    chk("rf data", 32'h1, 32'(rf_tx_data));
    repeat (40) @(posedge aclk);
    chk("pulse pin", 32'h0, 32'(link.tx_data_input));
    wr(REG_TXD, 32'h1);
    repeat (PULSE_MIN_CYC + PMAX + 50) @(posedge aclk);
    stat(d);
    chk("long flag", 32'h1, 32'(d[STAT_LONG_BIT]));
    $display("test pulse done");
    conclude();
  end
endmodule
